/* File: logic/sccs_regs.svh */
/*
  Register offsets, field positions, reset values and timing counts of the
  system clock select block.
  Assumes a 32-bit APB with byte addresses and a 100 MHz pclk.
*/
`ifndef SCCS_REGS_SVH
`define SCCS_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define SCCS_OFF_OSC_CTRL 12'h000
`define SCCS_OFF_IRQ_STATUS 12'h004
`define SCCS_OFF_IRQ_MASK 12'h008

// ----------------------------------------------------------------
// Oscillator control fields and reset value
// ----------------------------------------------------------------
`define SCCS_OSC_FREQ_HI 6
`define SCCS_OSC_FREQ_LO 4
`define SCCS_OSC_FORCE_BIT 0
`define SCCS_FREQ_RESET 3'h6

// ----------------------------------------------------------------
// Interrupt status / mask bit positions
// ----------------------------------------------------------------
`define SCCS_IRQ_FAIL 0
`define SCCS_IRQ_WARM 1
`define SCCS_IRQ_FAST 2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCCS_WARMUP_EDGES 11'h400
`define SCCS_CLK_PERIOD_NS 10
`define SCCS_FAIL_TIME_NS 2000
`define SCCS_FAIL_CYCLES (`SCCS_FAIL_TIME_NS / `SCCS_CLK_PERIOD_NS)

`endif

/* File: logic/sccs_pkg.sv */
/*
  Types shared by the system clock select block: clock modes, selector
  states, pin carrier and the state records of the synchroniser and the external clock watcher.
  Assumes nothing of its surroundings.
*/
package sccs_pkg;

  // ----------------------------------------------------------------
  // Clock mode field of the configuration word
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    low_gain_crystal_mode = 3'h0,
    mid_gain_crystal_mode = 3'h1,
    high_gain_crystal_mode = 3'h2,
    driven_clk_in_mode = 3'h3,
    resistor_cap_clkout_mode = 3'h4,
    resistor_cap_gpio_mode = 3'h5,
    internal_clkout_mode = 3'h6,
    internal_gpio_mode = 3'h7
  } sccs_mode_type;

  typedef enum logic [1:0] {st_warmup, st_ext, st_int, st_failed} sccs_sel_state_type;

  typedef struct packed {
    logic out;
    logic oe_n;
  } sccs_pin_type;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sccs_sync_type;

  typedef struct packed {
    logic [10:0] edge_cnt;
    logic warm_done;
    logic [15:0] idle_cnt;
    logic fail;
  } sccs_watch_type;

  // Crystal modes need the warm-up count
  function automatic logic sccs_is_xtal(input sccs_mode_type m);
    return m inside {low_gain_crystal_mode, mid_gain_crystal_mode, high_gain_crystal_mode};
  endfunction : sccs_is_xtal

  // Modes whose clock comes from outside the chip
  function automatic logic sccs_is_ext(input sccs_mode_type m);
    return sccs_is_xtal(m) || m inside {driven_clk_in_mode, resistor_cap_clkout_mode, resistor_cap_gpio_mode};
  endfunction : sccs_is_ext

endpackage : sccs_pkg

/* File: logic/sccs_sync3.sv */
/*
  Three-stage synchroniser for a level from outside the pclk domain.
  Assumes the input may change at any time; the output follows only once
  the second and third stages agree.
*/
`timescale 1ns/1ps
module sccs_sync3 import sccs_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic raw,
  output logic level
);

  sccs_sync_type q;
  sccs_sync_type d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // The first stage feeds only the second; nothing else looks at it
  always_comb begin
    d = q;
    d.s1 = raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.level = q.s3;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign level = q.level;

  // Output moves only on agreement of the last two stages
  sync_agree_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.level != $past(q.level) |-> $past(q.s2) == $past(q.s3) && q.level == $past(q.s3))
    else $error("synchroniser output moved without agreement");

endmodule : sccs_sync3

/* File: logic/sccs_ext_watch.sv */
/*
  Watches the synchronised external clock: counts edges for the crystal
  warm-up and flags a missing clock for the fail monitor.
  Assumes ext_edge is a one-cycle pulse per external rising edge and
  restart a one-cycle pulse from the selector.
*/
`timescale 1ns/1ps
`include "sccs_regs.svh"
module sccs_ext_watch import sccs_pkg::*; #(
  parameter logic [10:0] WARM_COUNT = `SCCS_WARMUP_EDGES,
  parameter logic [15:0] FAIL_CYCLES = 16'(`SCCS_FAIL_CYCLES)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic ext_edge,
  input wire logic restart,
  input wire logic monitor_en,
  output logic warm_done,
  output logic ext_fail
);

  sccs_watch_type q;
  sccs_watch_type d;

  // ----------------------------------------------------------------
  // Warm-up count and idle timeout
  // ----------------------------------------------------------------
  // Fail stays sticky until the next restart; recovering needs a new start
  always_comb begin
    d = q;
    if (restart) begin
      d = '0;
    end else begin
      if (ext_edge && !q.warm_done) begin
        d.edge_cnt = q.edge_cnt + 11'h001;
        if (d.edge_cnt == WARM_COUNT) begin
          d.warm_done = 1'b1;
        end
      end
      if (!monitor_en || ext_edge) begin
        d.idle_cnt = '0;
      end else if (q.idle_cnt != FAIL_CYCLES) begin
        d.idle_cnt = q.idle_cnt + 16'h0001;
      end
      if (monitor_en && d.idle_cnt == FAIL_CYCLES) begin
        d.fail = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign warm_done = q.warm_done;
  assign ext_fail = q.fail;

  warmup_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(q.warm_done) |-> $past(q.edge_cnt) == WARM_COUNT - 11'h001)
    else $error("warm-up ended at the wrong edge count");

  fail_timeout_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(q.fail) |-> $past(q.idle_cnt) == FAIL_CYCLES - 16'h0001)
    else $error("fail flagged at the wrong idle count");

endmodule : sccs_ext_watch

/* File: logic/sccs_top.sv */
/*
  System clock select: mode strap capture, source selector with warm-up,
  two-speed start and fail monitor, Fosc/4 clock output, pin muxing of the
  two oscillator pins, APB register file and interrupt.
  Assumes a 100 MHz pclk, an APB master, straps stable at reset release,
  asynchronous oscillator pins and same-domain port and oscillator ticks.
*/
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "sccs_regs.svh"

module sccs_top import sccs_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] cfg_clk_mode,
  input wire logic cfg_fail_mon_en,
  input wire logic cfg_two_speed_en,
  input wire logic sleep_wake,
  input wire logic int_osc_tick,
  input wire logic fast_osc_stable_raw,
  input wire logic slow_osc_stable_raw,
  input wire logic porta_bit7_pin_in,
  input wire logic [1:0] gpio_out,
  input wire logic [1:0] gpio_drive,
  output logic porta_bit6_pin_out,
  output logic porta_bit6_pin_oe_n,
  output logic porta_bit7_pin_out,
  output logic porta_bit7_pin_oe_n,
  output logic ext_clk_selected,
  output logic [2:0] int_freq_sel,
  output logic exec_hold,
  output logic irq
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cfg_taken;
    sccs_mode_type mode;
    logic fail_mon_en;
    logic two_speed_en;
    sccs_sel_state_type state;
    logic restart;
    logic ext_selected;
    logic exec_hold;
    logic [2:0] freq_sel;
    logic force_int;
    logic ext_prev;
    logic fast_prev;
    logic div;
    logic clkout;
    sccs_pin_type pin6;
    sccs_pin_type pin7;
    logic [2:0] status;
    logic [2:0] mask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } sccs_top_state_type;

  sccs_top_state_type q;
  sccs_top_state_type d;

  logic ext_lvl;
  logic fast_rdy;
  logic slow_rdy;
  logic warm_done;
  logic ext_fail;
  logic ext_rise;
  logic fast_rise;
  logic xtal;
  logic ext_mode;
  logic setup;
  logic wr_en;
  logic src_tick;
  logic mapped;
  logic [2:0] ev;
  logic [2:0] clr;

  // ----------------------------------------------------------------
  // Synchronisers and external clock watcher
  // ----------------------------------------------------------------
  sccs_sync3 u_sync_ext (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .raw(porta_bit7_pin_in),
    .level(ext_lvl)
  );

  sccs_sync3 u_sync_fast (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .raw(fast_osc_stable_raw),
    .level(fast_rdy)
  );

  sccs_sync3 u_sync_slow (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .raw(slow_osc_stable_raw),
    .level(slow_rdy)
  );

  // Monitor only once running external; a crystal that has not yet started
  // would otherwise look like a failed one
  sccs_ext_watch u_watch (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .ext_edge(ext_rise),
    .restart(q.restart),
    .monitor_en(q.fail_mon_en && q.state == st_ext),
    .warm_done(warm_done),
    .ext_fail(ext_fail)
  );

  // Helper by pin: the port logic's own value and direction
  function automatic sccs_pin_type gpio_pin(input logic o, input logic drv);
    return '{out: o, oe_n: ~drv};
  endfunction : gpio_pin

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    ev = '0;
    clr = '0;
    d.restart = 1'b0;
    ext_rise = ext_lvl & ~q.ext_prev;
    fast_rise = fast_rdy & ~q.fast_prev;
    d.ext_prev = ext_lvl;
    d.fast_prev = fast_rdy;
    xtal = sccs_is_xtal(q.mode);
    ext_mode = sccs_is_ext(q.mode);

    // Straps are caught once, after reset release
    if (!q.cfg_taken) begin
      d.cfg_taken = 1'b1;
      d.mode = sccs_mode_type'(cfg_clk_mode);
      d.fail_mon_en = cfg_fail_mon_en;
      d.two_speed_en = cfg_two_speed_en | cfg_fail_mon_en;
      d.restart = 1'b1;
    end else begin
      unique case (q.state)
        st_warmup: begin
          // Wait one cycle after restart so a stale done is not seen
          if (!ext_mode) begin
            d.state = st_int;
          end else if (!q.restart && (!xtal || warm_done)) begin
            d.state = st_ext;
            ev[`SCCS_IRQ_WARM] = xtal;
          end
        end
        st_ext: begin
          if (ext_fail) begin
            d.state = st_failed;
            ev[`SCCS_IRQ_FAIL] = 1'b1;
          end else if (sleep_wake && xtal) begin
            d.state = st_warmup;
            d.restart = 1'b1;
          end
        end
        st_int: begin
          d.state = st_int;
        end
        st_failed: begin
          d.state = st_failed;
        end
      endcase
    end

    // APB: zero-wait answer, pready high in every access phase
    setup = psel & ~penable;
    wr_en = psel & penable & q.pready & pwrite;
    mapped = paddr inside {`SCCS_OFF_OSC_CTRL, `SCCS_OFF_IRQ_STATUS, `SCCS_OFF_IRQ_MASK};
    d.pready = setup;
    d.pslverr = setup & ~mapped;
    d.prdata = 32'h0000_0000;
    if (setup && !pwrite) begin
      unique case (paddr)
        `SCCS_OFF_OSC_CTRL: begin
          // Bit 7 is left zero
          d.prdata[7:0] = {1'b0, q.freq_sel, q.ext_selected, fast_rdy, slow_rdy, q.force_int};
        end
        `SCCS_OFF_IRQ_STATUS: begin
          d.prdata[2:0] = q.status;
        end
        `SCCS_OFF_IRQ_MASK: begin
          d.prdata[2:0] = q.mask;
        end
        default: begin
          d.prdata = 32'h0000_0000;
        end
      endcase
    end
    if (wr_en) begin
      unique case (paddr)
        `SCCS_OFF_OSC_CTRL: begin
          d.freq_sel = pwdata[`SCCS_OSC_FREQ_HI:`SCCS_OSC_FREQ_LO];
          d.force_int = pwdata[`SCCS_OSC_FORCE_BIT];
        end
        `SCCS_OFF_IRQ_STATUS: begin
          clr = pwdata[2:0];
        end
        `SCCS_OFF_IRQ_MASK: begin
          d.mask = pwdata[2:0];
        end
        default: begin
          clr = '0;
        end
      endcase
    end

    // Source selection; force bit overrides the strap mode at once
    d.ext_selected = (d.state == st_ext) & ~d.force_int;
    d.exec_hold = (d.state == st_warmup) & ~d.two_speed_en;

    // Fosc/4: toggle every second tick of the running source
    src_tick = q.ext_selected ? ext_rise : int_osc_tick;
    if (src_tick) begin
      d.div = ~q.div;
      if (q.div) begin
        d.clkout = ~q.clkout;
      end
    end

    // Pin muxing; crystal modes leave both pins to the oscillator
    d.pin6 = '{out: 1'b0, oe_n: 1'b1};
    d.pin7 = '{out: 1'b0, oe_n: 1'b1};
    if (q.cfg_taken) begin
      unique case (q.mode)
        low_gain_crystal_mode, mid_gain_crystal_mode, high_gain_crystal_mode: begin
          d.pin6 = '{out: 1'b0, oe_n: 1'b1};
        end
        driven_clk_in_mode, resistor_cap_gpio_mode: begin
          d.pin6 = gpio_pin(gpio_out[0], gpio_drive[0]);
        end
        resistor_cap_clkout_mode: begin
          d.pin6 = '{out: q.clkout, oe_n: 1'b0};
        end
        internal_clkout_mode: begin
          d.pin6 = '{out: q.clkout, oe_n: 1'b0};
          d.pin7 = gpio_pin(gpio_out[1], gpio_drive[1]);
        end
        internal_gpio_mode: begin
          d.pin6 = gpio_pin(gpio_out[0], gpio_drive[0]);
          d.pin7 = gpio_pin(gpio_out[1], gpio_drive[1]);
        end
      endcase
    end

    // Sticky events; a new event wins over a clear in the same cycle
    ev[`SCCS_IRQ_FAST] = fast_rise;
    d.status = (q.status & ~clr) | ev;
    d.irq = |(d.status & d.mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.freq_sel <= `SCCS_FREQ_RESET;
      q.exec_hold <= 1'b1;
      q.pin6 <= '{out: 1'b0, oe_n: 1'b1};
      q.pin7 <= '{out: 1'b0, oe_n: 1'b1};
    end else if (ce) begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign porta_bit6_pin_out = q.pin6.out;
  assign porta_bit6_pin_oe_n = q.pin6.oe_n;
  assign porta_bit7_pin_out = q.pin7.out;
  assign porta_bit7_pin_oe_n = q.pin7.oe_n;
  assign ext_clk_selected = q.ext_selected;
  assign int_freq_sel = q.freq_sel;
  assign exec_hold = q.exec_hold;
  assign irq = q.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence osc_read_setup;
    ce && psel && !penable && !pwrite && paddr == `SCCS_OFF_OSC_CTRL;
  endsequence

  sequence osc_write_access;
    ce && psel && penable && pwrite && q.pready && paddr == `SCCS_OFF_OSC_CTRL;
  endsequence

  mode_strap_held_a: assert property (q.cfg_taken |=> $stable(q.mode))
    else $error("clock mode changed after capture");

  bit7_reads_zero_a: assert property (osc_read_setup |=> q.pready && prdata[7] == 1'b0)
    else $error("oscillator control bit 7 not zero");

  ext_flag_readback_a: assert property (osc_read_setup |=> prdata[3] == $past(q.ext_selected))
    else $error("external active flag misread");

  ready_flags_a: assert property (osc_read_setup |=> prdata[2:1] == $past({fast_rdy, slow_rdy}))
    else $error("oscillator ready flags misread");

  freq_write_a: assert property (osc_write_access |=> int_freq_sel == $past(pwdata[6:4]))
    else $error("frequency select not written");

  force_internal_a: assert property (q.force_int |-> !ext_clk_selected)
    else $error("external clock selected while internal forced");

  driven_pin_gpio_a: assert property (ce && q.cfg_taken && q.mode == driven_clk_in_mode
    |=> porta_bit6_pin_oe_n == !$past(gpio_drive[0]))
    else $error("driven mode pin 6 not general I/O");

  resistor_clkout_pin_a: assert property (ce && q.cfg_taken && q.mode == resistor_cap_clkout_mode
    |=> !porta_bit6_pin_oe_n && porta_bit6_pin_out == $past(q.clkout))
    else $error("resistor-capacitor mode pin 6 not driving clock out");

  int_clkout_pins_a: assert property (ce && q.cfg_taken && q.mode == internal_clkout_mode
    |=> !porta_bit6_pin_oe_n && porta_bit7_pin_oe_n == !$past(gpio_drive[1]))
    else $error("internal clock-out pins wrong");

  fail_switch_a: assert property (ce && q.state == st_ext && ext_fail
    |=> q.state == st_failed && !ext_clk_selected ##1 q.status[`SCCS_IRQ_FAIL] || !ce)
    else $error("clock failure did not switch to internal");

  two_speed_run_a: assert property (q.cfg_taken && q.state == st_warmup && q.two_speed_en |-> !exec_hold)
    else $error("execution held during two-speed start");

  warmup_hold_a: assert property (q.cfg_taken && q.state == st_warmup && !q.two_speed_en |-> exec_hold)
    else $error("execution not held during warm-up");

endmodule : sccs_top

/* File: verification/sccs_ext_osc.sv */
/*
  Behavioural external oscillator on the clock input pin of the clock select block.
  Assumes the bench starts and stops it through run; a stopped source sits low.
*/
`timescale 1ns/1ps
module sccs_ext_osc #(
  parameter realtime HALF_NS = 31.3
) (
  input wire logic run,
  output logic clk_out
);
  // ----------------------------------------------------------------
  // Free oscillation
  // ----------------------------------------------------------------
  // Half period is off the pclk grid so only one edge in 100 lands on a sampling edge
  initial begin
    clk_out = 1'b0;
    forever begin
      #(HALF_NS);
      clk_out = run ? ~clk_out : 1'b0; // A dead crystal gives no edges
    end
  end
endmodule : sccs_ext_osc

/* File: verification/tb_top.sv */
/*
  Self-checking bench of the clock select block: APB register access, strap modes, pin muxing, warm-up,
  two-speed start, fail monitor and interrupt. Assumes the external oscillator model drives the clock pin.
*/
`timescale 1ns/1ps
`include "sccs_regs.svh"
module tb_top import sccs_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, b6_out, b6_oe_n, b7_out, b7_oe_n, ext_sel, exec_hold, irq, ext_clk;
  logic [2:0] mode = 3'h7, freq;
  logic fail_en = 1'b0, two_en = 1'b0, tick = 1'b0, fast_raw = 1'b0, slow_raw = 1'b1, osc_run = 1'b0, wake = 1'b0;
  logic [1:0] gpio_out = 2'h2, gpio_drive = 2'h3;
  int bad_count = 0, samples_checked = 0, ecnt = 0;

  // ----------------------------------------------------------------
  // Clock, internal tick, device under test, partner
  // ----------------------------------------------------------------
  initial forever #5 pclk = ~pclk;
  always @(posedge pclk) tick <= ~tick;
  always @(posedge ext_clk) ecnt++;
  sccs_ext_osc sccs_ext_osc_inst (.run(osc_run), .clk_out(ext_clk));
  sccs_top sccs_top_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_clk_mode(mode), .cfg_fail_mon_en(fail_en), .cfg_two_speed_en(two_en), .sleep_wake(wake),
    .int_osc_tick(tick), .fast_osc_stable_raw(fast_raw), .slow_osc_stable_raw(slow_raw),
    .porta_bit7_pin_in(ext_clk), .gpio_out(gpio_out), .gpio_drive(gpio_drive), .porta_bit6_pin_out(b6_out),
    .porta_bit6_pin_oe_n(b6_oe_n), .porta_bit7_pin_out(b7_out), .porta_bit7_pin_oe_n(b7_oe_n),
    .ext_clk_selected(ext_sel), .int_freq_sel(freq), .exec_hold(exec_hold), .irq(irq));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // Callers look at outputs once they have settled
    @(negedge pclk);
  endtask : apb

  // Straps change only under reset; the oscillator starts once reset is gone
  task automatic rst(input logic [2:0] m, input logic fm, input logic ts);
    @(posedge pclk);
    presetn <= 1'b0; osc_run <= 1'b0; mode <= m; fail_en <= fm; two_en <= ts;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    ecnt = 0;
    osc_run <= 1'b1;
  endtask : rst

  // Only the watchdog ends a wait that never completes
  task automatic wait_ext(input logic v);
    while (ext_sel !== v) @(negedge pclk);
  endtask : wait_ext

  // ----------------------------------------------------------------
  // Watchdog: three warm-ups plus the mode sweep take about 20000 cycles
  // ----------------------------------------------------------------
  initial begin
    #400_000;
    bad_count++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic e, p;
    int tg, n;
    rst(3'h7, 1'b0, 1'b0);
    apb(0, `SCCS_OFF_OSC_CTRL, 0, r, e);
    chk("osc_ctrl_reset", r, 32'h0000_0062);
    chk("freq_reset", freq, 32'h0000_0006);
    fast_raw <= 1'b1;
    repeat (8) @(negedge pclk);
    apb(0, `SCCS_OFF_IRQ_STATUS, 0, r, e);
    chk("status_fast", r, 32'h0000_0004);
    chk("irq_masked", irq, 0);
    apb(1, `SCCS_OFF_IRQ_MASK, 32'h0000_0004, r, e);
    repeat (3) @(negedge pclk);
    chk("irq_raised", irq, 1);
    apb(1, `SCCS_OFF_IRQ_STATUS, 32'h0000_0004, r, e);
    repeat (3) @(negedge pclk);
    chk("irq_cleared", irq, 0);
    apb(1, `SCCS_OFF_OSC_CTRL, 32'h0000_00ff, r, e);
    slow_raw <= 1'b0;
    repeat (8) @(negedge pclk);
    apb(0, `SCCS_OFF_OSC_CTRL, 0, r, e);
    chk("osc_ctrl_write", r, 32'h0000_0075);
    chk("freq_max", freq, 32'h0000_0007);
    apb(0, 12'h00c, 0, r, e);
    chk("unmapped_data", r, 0);
    chk("unmapped_err", e, 1);
    // Every strap mode: pin roles, clock output and initial source
    for (int m = 0; m < 8; m++) begin
      rst(m[2:0], 1'b0, 1'b0);
      repeat (20) @(negedge pclk);
      tg = 0;
      p = b6_out;
      repeat (64) begin @(negedge pclk); tg += (b6_out !== p); p = b6_out; end
      chk("pin6_oe_n", b6_oe_n, m < 3);
      chk("pin7_oe_n", b7_oe_n, m < 6);
      chk("pin7_out", b7_out, m > 5);
      chk("pin6_clkout", tg > 0, m == 4 || m == 6);
      chk("ext_start", ext_sel, m > 2 && m < 6);
      chk("hold_start", exec_hold, m < 3);
    end
    // Crystal warm-up without two-speed start
    rst(3'h1, 1'b0, 1'b0);
    apb(1, `SCCS_OFF_IRQ_MASK, 32'h0000_0002, r, e);
    chk("warm_hold", exec_hold, 1);
    wait_ext(1'b1);
    chk("warm_edges", ecnt >= 1024 && ecnt <= 1025, 1);
    repeat (3) @(negedge pclk);
    chk("warm_run", exec_hold, 0);
    chk("warm_irq", irq, 1);
    apb(0, `SCCS_OFF_OSC_CTRL, 0, r, e);
    chk("ext_flag", r, 32'h0000_006c);
    apb(1, `SCCS_OFF_OSC_CTRL, 32'h0000_0061, r, e);
    repeat (3) @(negedge pclk);
    chk("force_int", ext_sel, 0);
    apb(1, `SCCS_OFF_OSC_CTRL, 32'h0000_0060, r, e);
    repeat (3) @(negedge pclk);
    chk("back_ext", ext_sel, 1);
    // Wake from sleep in crystal mode repeats the warm-up
    @(posedge pclk);
    wake <= 1'b1;
    @(posedge pclk);
    wake <= 1'b0;
    repeat (3) @(negedge pclk);
    chk("wake_hold", exec_hold, 1);
    chk("wake_int", ext_sel, 0);
    wait_ext(1'b1);
    repeat (3) @(negedge pclk);
    chk("wake_run", exec_hold, 0);
    // Fail monitor forces two-speed start, then catches a stopped crystal
    rst(3'h2, 1'b1, 1'b0);
    repeat (20) @(negedge pclk);
    chk("two_speed_run", exec_hold, 0);
    chk("two_speed_int", ext_sel, 0);
    wait_ext(1'b1);
    apb(1, `SCCS_OFF_IRQ_MASK, 32'h0000_0001, r, e);
    osc_run <= 1'b0;
    n = 0;
    while (ext_sel !== 1'b0 && n < 400) begin @(negedge pclk); n++; end
    chk("fail_time", n >= 190 && n <= 210, 1);
    repeat (3) @(negedge pclk);
    chk("fail_irq", irq, 1);
    tally_and_finish();
  end
endmodule : tb_top
